// >>> rtl/i2cx_expander.sv
`timescale 1ns/1ns
module i2cx_expander (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [7:0] io_port_bits_in,
  output logic [7:0] io_port_bits_out,
  output logic [7:0] io_port_bits_oe,
  output logic [7:0] pullup_en,
  input wire logic addr_sel_low,
  input wire logic addr_sel_high,
  input wire logic abort_n,
  output logic alert_out,
  output logic alert_oe,
  output logic [6:0] slave_addr,
  output logic standby
);
  import i2cx_pkg::*;

  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic scl_d;
  logic sda_d;
  logic [7:0] pins_d;
  logic scl;
  logic sda;
  logic abort_ok;
  logic [7:0] pins;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic go;
  logic addr_hit;
  logic take_snap;
  logic wr_load;
  logic in_read;
  logic por_pend;
  logic [2:0] por_cnt;
  logic wrote;
  logic [7:0] def_level;
  i2cx_state_t state;
  logic [3:0] cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic rw;
  logic nak;
  logic byte_sel;
  logic [7:0] snap;
  logic [7:0] flags;
  logic [7:0] flags_hold;
  logic [7:0] level;
  logic [7:0] change;
  logic [7:0] new_evt;
  logic [7:0] oe_q1;
  logic [7:0] oe_q2;

  i2cx_sel_if sel ();

  i2cx_sel_class u_cls (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .sif(sel)
  );

  // Every pin crosses two flops; reset to idle-high so no false START/STOP
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      pins_d <= SNAP_RST;
    end else if (ce) begin
      sync1 <= {abort_n, addr_sel_high, addr_sel_low, sda_in, scl_in, io_port_bits_in};
      sync2 <= sync1;
      scl_d <= sync2[SCL_POS];
      sda_d <= sync2[SDA_POS];
      pins_d <= sync2[7:0];
    end
  end

  // Bus conditions, all taken from the second synchroniser stage
  assign scl = sync2[SCL_POS];
  assign sda = sync2[SDA_POS];
  assign abort_ok = sync2[ABORT_POS];
  assign pins = sync2[7:0];
  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  assign start = scl && scl_d && sda_d && !sda;
  assign stop = scl && scl_d && !sda_d && sda;
  assign go = ce && abort_ok && !start && !stop;

  assign sel.scl = scl;
  assign sel.sda = sda;
  assign sel.start = start;
  assign sel.stop = stop;
  assign sel.pin = {sync2[SEL_HI_POS], sync2[SEL_LO_POS]};

  // Snapshot on our address ack, and on the master ack that precedes port data
  assign addr_hit = state == ST_ADDR && scl_fall && cnt == BYTE_BITS && shift[7:1] == slave_addr;
  assign take_snap = go && (addr_hit || (state == ST_RACK && scl_fall && !nak && byte_sel));
  assign wr_load = go && state == ST_WDATA && scl_fall && cnt == BYTE_BITS;
  assign in_read = rw && state != ST_IDLE && state != ST_ADDR;
  assign level = ~(io_port_bits_oe | oe_q1 | oe_q2); // Just-released ports wait out the synchroniser
  assign change = (pins ^ snap) & level;
  assign new_evt = (pins ^ pins_d) & level;
  assign def_level = {{NIB{grp_on(sel.code_hi)}}, {NIB{grp_on(sel.code_lo)}}};

  // Address and pullups follow the latest pin verdict
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slave_addr <= SLAVE_ADDR_RST;
      pullup_en <= PULLUP_RST;
    end else if (ce) begin
      slave_addr <= {ADDR_TOP, hi_addr_bits(sel.code_hi), 2'(sel.code_lo)};
      pullup_en <= def_level;
    end
  end

  // Engine; abort wins over everything, as if a STOP had been seen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      nak <= 1'b0;
      byte_sel <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce) begin
      if (!abort_ok) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
        rw <= 1'b0;
      end else if (start) begin
        state <= ST_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
        rw <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE, ST_SKIP: begin
          end
          ST_ADDR, ST_WDATA: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == BYTE_BITS) begin
              if (state == ST_WDATA) begin
                state <= ST_WACK;
                sda_oe <= 1'b1;
              end else if (addr_hit) begin
                state <= ST_AACK;
                sda_oe <= 1'b1;
                rw <= shift[0];
              end else begin
                state <= ST_SKIP;
                rw <= 1'b0;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              cnt <= 4'h0;
              if (rw) begin
                state <= ST_RDATA;
                tx <= snap;
                byte_sel <= 1'b0;
                sda_oe <= ~snap[7];
              end else begin
                state <= ST_WDATA;
                sda_oe <= 1'b0;
              end
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              state <= ST_WDATA;
              cnt <= 4'h0;
              sda_oe <= 1'b0;
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (cnt[2:0] == LAST_BIT) begin
                state <= ST_RACK;
                sda_oe <= 1'b0;
              end else begin
                cnt <= cnt + 4'h1;
                tx <= {tx[6:0], 1'b0};
                sda_oe <= ~tx[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nak <= sda;
            end else if (scl_fall) begin
              cnt <= 4'h0;
              if (nak) begin
                state <= ST_SKIP;
              end else if (byte_sel) begin
                state <= ST_RDATA;
                tx <= pins;
                byte_sel <= 1'b0;
                sda_oe <= ~pins[7];
              end else begin
                state <= ST_RDATA;
                tx <= flags_hold;
                byte_sel <= 1'b1;
                sda_oe <= ~flags_hold[7];
              end
            end
          end
        endcase
      end
    end
  end

  // Transition flags; an edge in the clearing cycle survives the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      snap <= SNAP_RST;
      flags <= 8'h00;
      flags_hold <= 8'h00;
    end else if (ce) begin
      if (take_snap) begin
        snap <= pins;
        flags_hold <= flags;
        flags <= new_evt;
      end else if (wr_load) begin
        // Expect the written level on the pin so a write reads as no change
        snap <= shift;
        flags <= flags | change;
      end else begin
        flags <= flags | change;
      end
    end
  end

  // Alert: cleared at our ack, held off during reads, untouched by abort
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alert_oe <= 1'b0;
    end else if (ce) begin
      if (take_snap && state == ST_ADDR) begin
        alert_oe <= 1'b0;
      end else if (|flags && !in_read) begin
        alert_oe <= 1'b1;
      end
    end
  end

  // Port levels: defaults after power-up settle, again after each verdict until the first write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_pend <= 1'b1;
      por_cnt <= 3'h0;
      wrote <= 1'b0;
      io_port_bits_oe <= DRIVE_LOW_RST;
      oe_q1 <= DRIVE_LOW_RST;
      oe_q2 <= DRIVE_LOW_RST;
    end else if (ce) begin
      oe_q1 <= io_port_bits_oe;
      oe_q2 <= oe_q1;
      if (por_cnt != POR_SETTLE) begin
        por_cnt <= por_cnt + 3'h1; // Let the pin synchronisers fill first
      end
      if (wr_load) begin
        wrote <= 1'b1;
        io_port_bits_oe <= ~shift;
      end else if (por_pend && por_cnt == POR_SETTLE) begin
        por_pend <= 1'b0;
        io_port_bits_oe <= ~def_level;
      end else if (sel.done && !wrote) begin
        io_port_bits_oe <= ~def_level;
      end
    end
  end

  // Constant drive values and standby flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_out <= 1'b0;
      alert_out <= 1'b0;
      io_port_bits_out <= 8'h00;
      standby <= 1'b1;
    end else if (ce) begin
      sda_out <= 1'b0;
      alert_out <= 1'b0;
      io_port_bits_out <= 8'h00;
      standby <= state == ST_IDLE;
    end
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn || !ce);

  sequence s_addr_read;
    state == ST_AACK && scl_fall && rw && go;
  endsequence

  sequence s_data_out;
    state == ST_RDATA && sda_oe == ~tx[7];
  endsequence

  abort_idle_a: assert property (!abort_ok |=> state == ST_IDLE && !sda_oe)
    else $error("abort did not idle the engine");
  alert_keep_a: assert property (!abort_ok && alert_oe |=> alert_oe)
    else $error("abort disturbed the alert");
  ack_clear_a: assert property (take_snap && state == ST_ADDR |=> !alert_oe && flags == $past(new_evt))
    else $error("address ack did not clear flags and alert");
  addr_top_a: assert property (##1 slave_addr[6:4] == ADDR_TOP)
    else $error("address top bits wrong");
  group_pullup_a: assert property (1 |=> pullup_en[7:4] == {NIB{$past(sel.code_hi) != SEL_GND}}
    && pullup_en[3:0] == {NIB{$past(sel.code_lo) != SEL_GND}})
    else $error("pullup group mismatch");
  por_default_a: assert property (por_pend && por_cnt == POR_SETTLE && !wr_load
    |=> io_port_bits_oe == ~$past(def_level) && !por_pend)
    else $error("power-up default not loaded");
  write_port_a: assert property (wr_load |=> io_port_bits_oe == ~$past(shift) ##1 state == ST_WACK)
    else $error("written byte not applied");
  read_order_a: assert property (s_addr_read |=> s_data_out ##0 (tx == $past(snap)))
    else $error("read did not start with port data");
  alert_set_a: assert property (|flags && !in_read && !take_snap |=> alert_oe)
    else $error("input change did not raise alert");
  standby_a: assert property (state == ST_IDLE |=> standby)
    else $error("idle without standby");

endmodule : i2cx_expander

// >>> rtl/i2cx_pkg.sv
package i2cx_pkg;

  // Four ways a select pin can be tied; low-pin address bits equal the code
  typedef enum logic [1:0] {
    SEL_GND = 2'b00,
    SEL_VCC = 2'b01,
    SEL_SCL = 2'b10,
    SEL_SDA = 2'b11
  } i2cx_sel_t;

  // Slave engine states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_AACK  = 3'b010,
    ST_WDATA = 3'b011,
    ST_WACK  = 3'b100,
    ST_RDATA = 3'b101,
    ST_RACK  = 3'b110,
    ST_SKIP  = 3'b111
  } i2cx_state_t;

  localparam logic [2:0] ADDR_TOP = 3'b110;
  localparam logic [6:0] SLAVE_ADDR_RST = 7'h6d;
  localparam logic [7:0] PULLUP_RST = 8'hff;
  localparam logic [7:0] DRIVE_LOW_RST = 8'h00;
  localparam logic [7:0] SNAP_RST = 8'hff;
  localparam logic [2:0] POR_SETTLE = 3'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int NIB = 4;
  // Synchroniser bundle layout
  localparam int SYNC_W = 13;
  localparam int SCL_POS = 8;
  localparam int SDA_POS = 9;
  localparam int SEL_LO_POS = 10;
  localparam int SEL_HI_POS = 11;
  localparam int ABORT_POS = 12;
  localparam logic [12:0] SYNC_RST = 13'h1fff;

  // Address bits 3:2 from the high select pin
  function automatic logic [1:0] hi_addr_bits(input i2cx_sel_t c);
    logic [1:0] r;
    r = 2'b11;
    unique case (c)
      SEL_SCL: r = 2'b00;
      SEL_SDA: r = 2'b01;
      SEL_GND: r = 2'b10;
      SEL_VCC: r = 2'b11;
    endcase
    return r;
  endfunction : hi_addr_bits

  // Any connection but ground turns a nibble's pullups on and defaults it high
  function automatic logic grp_on(input i2cx_sel_t c);
    return c != SEL_GND;
  endfunction : grp_on

endpackage : i2cx_pkg

// >>> rtl/i2cx_sel_class.sv
`timescale 1ns/1ns
module i2cx_sel_class (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  i2cx_sel_if.cls sif
);
  import i2cx_pkg::*;

  logic busy;
  logic [1:0] off_scl;
  logic [1:0] off_sda;
  i2cx_sel_t next_code [2];

  // Verdict per pin at the end of a transmission; SCL wins a tie with SDA
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!off_scl[i]) begin
        next_code[i] = SEL_SCL;
      end else if (!off_sda[i]) begin
        next_code[i] = SEL_SDA;
      end else begin
        next_code[i] = sif.pin[i] ? SEL_VCC : SEL_GND;
      end
    end
  end

  // Watch each pin against both bus lines over one whole transmission
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      off_scl <= 2'b00;
      off_sda <= 2'b00;
      sif.known <= 1'b0;
      sif.done <= 1'b0;
      sif.code_lo <= SEL_VCC;
      sif.code_hi <= SEL_VCC;
    end else if (ce) begin
      sif.done <= 1'b0;
      if (sif.start && !busy) begin
        busy <= 1'b1;
        off_scl <= 2'b00;
        off_sda <= 2'b00;
      end else if (sif.stop && busy) begin
        busy <= 1'b0;
        sif.known <= 1'b1;
        sif.done <= 1'b1;
        sif.code_lo <= next_code[0];
        sif.code_hi <= next_code[1];
      end else if (busy) begin
        off_scl <= off_scl | (sif.pin ^ {2{sif.scl}});
        off_sda <= off_sda | (sif.pin ^ {2{sif.sda}});
      end
      // Until a transmission is seen, only plain levels can be told apart
      if (!sif.known && !busy) begin
        sif.code_lo <= sif.pin[0] ? SEL_VCC : SEL_GND;
        sif.code_hi <= sif.pin[1] ? SEL_VCC : SEL_GND;
      end
    end
  end

  level_only_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
    !sif.known && !busy |=> sif.code_lo == (sif.known ? sif.code_lo : ($past(sif.pin[0]) ? SEL_VCC : SEL_GND)))
    else $error("select pin not read as plain level before first transmission");

  track_scl_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
    sif.stop && busy && !off_scl[0] && (sif.pin[0] == sif.scl) |=> sif.code_lo == SEL_SCL && sif.done)
    else $error("pin tracking SCL not classed as SCL");

endmodule : i2cx_sel_class

// >>> rtl/i2cx_sel_if.sv
`timescale 1ns/1ns
interface i2cx_sel_if;
  import i2cx_pkg::*;
  logic scl;
  logic sda;
  logic start;
  logic stop;
  logic [1:0] pin;
  i2cx_sel_t code_lo;
  i2cx_sel_t code_hi;
  logic known;
  logic done;
  modport eng (output scl, sda, start, stop, pin, input code_lo, code_hi, known, done);
  modport cls (input scl, sda, start, stop, pin, output code_lo, code_hi, known, done);
endinterface : i2cx_sel_if

// >>> tb/i2cx_master_model.sv
`timescale 1ns/1ns
module i2cx_master_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // Half a 400 ns link period in system clocks
  localparam int HALF = 4;

  // Bus idles released; SCL stands still outside frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : wt

  // SDA falls while SCL is high
  task automatic start_cond();
    wt(HALF);
    sda_low = 1'b1;
    wt(HALF);
    scl = 1'b0;
  endtask : start_cond

  // Data changes one clock after SCL falls so hold time is never zero
  task automatic put_bit(input logic b, output logic smp);
    wt(1);
    sda_low = ~b;
    wt(HALF - 1);
    scl = 1'b1;
    wt(HALF / 2);
    smp = sda_line;
    wt(HALF / 2);
    scl = 1'b0;
  endtask : put_bit

  // SDA rises while SCL is high, then the bus is left idle
  task automatic stop_cond();
    wt(1);
    sda_low = 1'b1;
    wt(HALF - 1);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b0;
    wt(HALF);
  endtask : stop_cond

  // Address or data byte, MSB first, then the slave's acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], a);
    end
    put_bit(1'b1, a);
    ack = ~a;
  endtask : send_byte

  // Master alone decides how many bytes it takes; last one gets a NAK
  task automatic recv_byte(output logic [7:0] d, input logic last);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i]);
    end
    put_bit(last, a);
  endtask : recv_byte
endmodule : i2cx_master_model

// >>> tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import i2cx_pkg::*;
  logic clk, rstn, ce, abort_n, scl, m_sda_low, sda_line, ack;
  logic sda_out, sda_oe, alert_out, alert_oe, standby, sel_lo_pin, sel_hi_pin;
  logic [7:0] ext, port_in, port_out, port_oe, pullup_en, rd;
  logic [6:0] slave_addr;
  i2cx_sel_t sel_lo, sel_hi;
  int errors, total_checks;
  i2cx_sel_t codes [4] = '{SEL_GND, SEL_VCC, SEL_SCL, SEL_SDA};
  logic [1:0] hi_bits [4] = '{2'b10, 2'b11, 2'b00, 2'b01};

  // Open-drain wire with pull-up; ports follow their released or driven level
  assign sda_line = ~(m_sda_low | sda_oe);
  assign port_in = ~port_oe & ext;

  function automatic logic tie_level(input i2cx_sel_t c, input logic s, input logic d);
    return (c == SEL_GND) ? 1'b0 : (c == SEL_VCC) ? 1'b1 : (c == SEL_SCL) ? s : d;
  endfunction : tie_level

  assign sel_lo_pin = tie_level(sel_lo, scl, sda_line);
  assign sel_hi_pin = tie_level(sel_hi, scl, sda_line);

  i2cx_master_model master (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(m_sda_low));

  i2cx_expander dut (
    .clk(clk), .rstn(rstn), .ce(ce), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .io_port_bits_in(port_in), .io_port_bits_out(port_out),
    .io_port_bits_oe(port_oe), .pullup_en(pullup_en), .addr_sel_low(sel_lo_pin),
    .addr_sel_high(sel_hi_pin), .abort_n(abort_n), .alert_out(alert_out), .alert_oe(alert_oe),
    .slave_addr(slave_addr), .standby(standby)
  );

  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : wt

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Frame to an address no expander uses; only serves to reclassify pins
  task automatic dummy_frame();
    master.start_cond();
    master.send_byte(8'h20, ack);
    master.stop_cond();
    wt(4);
  endtask : dummy_frame

  // SDA-tied high pin reads as high before any transmission
  task automatic t_powerup();
    chk({7'h0, alert_oe}, 8'h00);
    chk({7'h0, standby}, 8'h01);
    rstn = 1'b1;
    wt(8);
    chk({1'b0, slave_addr}, 8'h6c);
    chk(pullup_en, 8'hf0);
    chk(port_oe, 8'h0f);
    chk({7'h0, alert_oe}, 8'h00);
  endtask : t_powerup

  // Every pairing of ties; defaults still reload because nothing was written yet
  task automatic t_classify();
    logic [7:0] pu;
    for (int h = 0; h < 4; h++) begin
      for (int l = 0; l < 4; l++) begin
        sel_hi = codes[h];
        sel_lo = codes[l];
        dummy_frame();
        pu = {(h != 0) ? 4'hf : 4'h0, (l != 0) ? 4'hf : 4'h0};
        chk({1'b0, slave_addr}, {1'b0, 3'b110, hi_bits[h], l[1:0]});
        chk(pullup_en, pu);
        chk(port_oe, ~pu);
      end
    end
  endtask : t_classify

  // Back-to-back data bytes, each sets all ports; no alert from writes
  task automatic t_write();
    sel_hi = SEL_GND;
    sel_lo = SEL_GND;
    dummy_frame();
    master.start_cond();
    master.send_byte(8'hd0, ack);
    chk({7'h0, ack}, 8'h01);
    chk({7'h0, standby}, 8'h00);
    master.send_byte(8'ha5, ack);
    chk(port_oe, 8'h5a);
    master.send_byte(8'h3c, ack);
    chk(port_oe, 8'hc3);
    chk(port_out, 8'h00);
    chk({7'h0, sda_out}, 8'h00);
    chk({7'h0, alert_out}, 8'h00);
    master.stop_cond();
    wt(3);
    chk({7'h0, standby}, 8'h01);
    chk({7'h0, alert_oe}, 8'h00);
  endtask : t_write

  // Input change raises alert; read returns ports then held flags
  task automatic t_read();
    ext[2] = 1'b0;
    wt(6);
    chk({7'h0, alert_oe}, 8'h01);
    master.start_cond();
    master.send_byte(8'hd1, ack);
    chk({7'h0, ack}, 8'h01);
    chk({7'h0, alert_oe}, 8'h00);
    master.recv_byte(rd, 1'b0);
    chk(rd, 8'h38);
    master.recv_byte(rd, 1'b1);
    chk(rd, 8'h04);
    master.stop_cond();
    wt(4);
    chk({7'h0, alert_oe}, 8'h00);
  endtask : t_read

  // Abort in mid-address with an alert pending
  task automatic t_abort();
    ext[2] = 1'b1;
    wt(6);
    chk({7'h0, alert_oe}, 8'h01);
    master.start_cond();
    master.put_bit(1'b1, ack);
    master.put_bit(1'b1, ack);
    master.put_bit(1'b0, ack);
    abort_n = 1'b0;
    wt(3);
    abort_n = 1'b1;
    wt(4);
    chk({7'h0, standby}, 8'h01);
    chk({7'h0, sda_oe}, 8'h00);
    chk({7'h0, alert_oe}, 8'h01);
    master.stop_cond();
    master.start_cond();
    master.send_byte(8'hd0, ack);
    chk({7'h0, ack}, 8'h01);
    master.stop_cond();
    wt(3);
    chk({7'h0, alert_oe}, 8'h00);
  endtask : t_abort

  // Clock enable low freezes the pin path; the change only shows once it runs again
  task automatic t_freeze();
    ce = 1'b0;
    ext[2] = 1'b0;
    wt(6);
    chk({7'h0, alert_oe}, 8'h00);
    ce = 1'b1;
    wt(6);
    chk({7'h0, alert_oe}, 8'h01);
    ext[2] = 1'b1;
  endtask : t_freeze

  // Second power-on reset brings back pin-selected defaults
  task automatic t_rereset();
    rstn = 1'b0;
    wt(2);
    chk({7'h0, alert_oe}, 8'h00);
    rstn = 1'b1;
    wt(8);
    chk(port_oe, 8'hff);
    chk(pullup_en, 8'h00);
    chk({1'b0, slave_addr}, 8'h68);
  endtask : t_rereset

  initial begin
    rstn = 1'b0;
    abort_n = 1'b1;
    ce = 1'b1;
    ext = 8'hff;
    sel_hi = SEL_SDA;
    sel_lo = SEL_GND;
    errors = 0;
    total_checks = 0;
    wt(3);
    t_powerup();
    t_classify();
    t_write();
    t_read();
    t_abort();
    t_freeze();
    t_rereset();
    end_of_test();
  end

  // Whole run needs about 2300 clocks
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule : testbench
